// ---- pkg/cpu_xfer_defines.svh ----
`ifndef CPU_XFER_DEFINES_SVH
`define CPU_XFER_DEFINES_SVH
`define REG_CMD 8'h00
`define REG_ACC 8'h04
`define REG_SP 8'h08
`define REG_DIR 8'h0c
`define REG_IDX 8'h10
`define REG_DBR 8'h14
`define REG_PC 8'h18
`define REG_PSTAT 8'h1c
`define REG_MODE 8'h20
`define REG_STKB 8'h24
`define REG_ISTAT 8'h28
`define REG_IMASK 8'h2c
`define REG_SVC 8'h30
`define CMD_OP_MSB 3
`define CMD_BANK_LSB 8
`define CMD_BANK_MSB 15
`define MODE_EMU 0
`define P_N 7
`define P_M 5
`define P_X 4
`define P_D 3
`define P_I 2
`define P_Z 1
`define PSTAT_RESET 8'h34
`define SP_RESET 16'h01ff
`define SP_EMU_HIGH 8'h01
`define BRK_LEN 16'h0002
`define MOVE_LEN 16'h0003
`define OP_LEN 16'h0001
`define EV_W 5
`define SVC_WAIT 0
`define SVC_CMD 1
`define SVC_PEND_LSB 4
`define PINS_IDLE 5'h1f
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- pkg/cpu_xfer_pkg.sv ----
package cpu_xfer_pkg;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_MOVE_ASC = 4'h1, OP_MOVE_DESC = 4'h2, OP_ACC_TO_SP = 4'h3,
        OP_SP_TO_ACC = 4'h4, OP_ACC_TO_DIR = 4'h5, OP_DIR_TO_ACC = 4'h6,
        OP_ACC_TO_IDX = 4'h7, OP_IDX_TO_ACC = 4'h8, OP_PUSH_STATUS = 4'h9,
        OP_PULL_STATUS = 4'ha, OP_BREAK = 4'hb, OP_RETURN = 4'hc, OP_WAIT = 4'hd
    } op_type;
    typedef enum logic [1:0] {ST_RUN = 2'b01, ST_WAIT = 2'b10} state_type;
    typedef struct packed {
        logic rst_n;
        logic abort_n;
        logic nmi_n;
        logic irq_n;
        logic ready;
    } pins_type;
    typedef struct packed {
        logic irq;
        logic nmi;
        logic abort;
        logic rst;
    } src_type;
endpackage

// ---- hw/cpu_transfer_interrupt_semantics.sv ----
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "cpu_xfer_defines.svh"
// How it works
// RULE1: Block moves load bank register from operand
// RULE2: Priority reset, abort, nonmaskable, then maskable
// RULE3: Transfers drive full sixteen source bits
// RULE4: Destination width sets stored bits, flags
// RULE5: Acc/stack and acc/direct transfers always sixteen
// RULE6: Status push and pull move one byte
// RULE7: Emulation forces stack high byte 01
// RULE8: Native acc to stack copies high byte
// RULE9: Stack to acc writes all sixteen bits
// RULE10: Break skips its signature byte
// RULE11: Break return address follows signature byte
// RULE12: Narrow accumulator keeps hidden high byte
// RULE13: Wait instruction drives wait indication low
// RULE14: Unused interrupt and ready inputs tied high
// RULE15: Reset or interrupts end the wait state; here only reset, nonmaskable and maskable requests wake it, abort does not
// RULE16: Losing requests stay pending for later
module cpu_transfer_interrupt_semantics
    import cpu_xfer_pkg::*;
#(
    parameter logic [15:0] VEC_RESET = 16'h0000,
    parameter logic [15:0] VEC_ABORT = 16'h0010,
    parameter logic [15:0] VEC_NMI = 16'h0020,
    parameter logic [15:0] VEC_IRQ = 16'h0030,
    parameter logic [15:0] VEC_BRK = 16'h0040
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic system_reset_n,
    input wire logic abort_n,
    input wire logic nonmaskable_irq_n,
    input wire logic maskable_irq_n,
    input wire logic ready_input,
    output logic irq,
    output logic waiting_indication_n
);
    logic [7:0] aw_addr_q;
    logic aw_have_q, w_have_q, wr_fire, wr_hit, rd_hit, rd_clear;
    logic [31:0] w_data_q, wmask, rd_val;
    logic [3:0] w_strb_q;
    logic [15:0] acc_q, sp_q, dir_q, idx_q, pc_q, saved_pc_q, wval, vec;
    logic [7:0] dbr_q, pstat_q, saved_p_q, stkb_q, cmd_bank_q;
    logic emu_q, cmd_pend_q, abort_pend_q, nmi_pend_q, exec_fire, svc_fire, wake;
    logic [`EV_W-1:0] istat_q, imask_q, ev;
    op_type cmd_op_q;
    state_type state_q;
    pins_type pins_in, meta_q, sync_q, prev_q;
    src_type grant;

    function automatic logic [7:0] set_nz(input logic [7:0] p, input logic [15:0] v,
                                          input logic narrow);
        logic [7:0] r;
        r = p;
        r[`P_N] = narrow ? v[7] : v[15];
        r[`P_Z] = narrow ? (v[7:0] == 8'h00) : (v == 16'h0000);
        return r;
    endfunction

    // AXI4-Lite write side: address and data taken in either order
    assign wr_fire = aw_have_q && w_have_q && !bvalid;
    for (genvar g = 0; g < 4; g++) begin : g_mask
        assign wmask[g*8 +: 8] = {8{w_strb_q[g]}};
    end
    assign wval = 16'(w_data_q & wmask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (awvalid && awready) begin
            aw_addr_q <= awaddr;
            aw_have_q <= 1'b1;
            awready <= 1'b0;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            w_have_q <= 1'b1;
            wready <= 1'b0;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    always_comb begin
        if (aw_addr_q == `REG_CMD || aw_addr_q == `REG_ACC || aw_addr_q == `REG_SP) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `REG_DIR || aw_addr_q == `REG_IDX) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `REG_DBR || aw_addr_q == `REG_PC) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `REG_PSTAT || aw_addr_q == `REG_MODE) begin
            wr_hit = 1'b1;
        end else if (aw_addr_q == `REG_STKB || aw_addr_q == `REG_IMASK) begin
            wr_hit = 1'b1;
        end else begin
            // Status and service words are read only, still answered OKAY
            wr_hit = aw_addr_q == `REG_ISTAT || aw_addr_q == `REG_SVC;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read side
    always_comb begin
        rd_hit = 1'b1;
        if (araddr == `REG_CMD) begin
            rd_val = {16'h0000, cmd_bank_q, 4'h0, cmd_op_q};
        end else if (araddr == `REG_ACC) begin
            rd_val = {16'h0000, acc_q};
        end else if (araddr == `REG_SP) begin
            rd_val = {16'h0000, sp_q};
        end else if (araddr == `REG_DIR) begin
            rd_val = {16'h0000, dir_q};
        end else if (araddr == `REG_IDX) begin
            rd_val = {16'h0000, idx_q};
        end else if (araddr == `REG_DBR) begin
            rd_val = {24'h000000, dbr_q};
        end else if (araddr == `REG_PC) begin
            rd_val = {16'h0000, pc_q};
        end else if (araddr == `REG_PSTAT) begin
            rd_val = {24'h000000, pstat_q};
        end else if (araddr == `REG_MODE) begin
            rd_val = {31'h00000000, emu_q};
        end else if (araddr == `REG_STKB) begin
            rd_val = {24'h000000, stkb_q};
        end else if (araddr == `REG_ISTAT) begin
            rd_val = {27'h0000000, istat_q};
        end else if (araddr == `REG_IMASK) begin
            rd_val = {27'h0000000, imask_q};
        end else if (araddr == `REG_SVC) begin
            rd_val = {24'h000000, !sync_q.irq_n, nmi_pend_q, abort_pend_q, !sync_q.rst_n,
                      2'b00, cmd_pend_q, state_q == ST_WAIT};
        end else begin
            rd_val = 32'h0000_0000;
            rd_hit = 1'b0;
        end
    end
    assign rd_clear = arvalid && arready && araddr == `REG_ISTAT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Pin synchronisers; idle level is high so unused inputs stay quiet
    assign pins_in = {system_reset_n, abort_n, nonmaskable_irq_n, maskable_irq_n, ready_input};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= `PINS_IDLE; // RULE14
            sync_q <= `PINS_IDLE;
            prev_q <= `PINS_IDLE;
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge latches; a new edge beats the clear of its own service
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            abort_pend_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end else begin
            abort_pend_q <= (abort_pend_q && !grant.abort) || (prev_q.abort_n && !sync_q.abort_n); // RULE16
            nmi_pend_q <= (nmi_pend_q && !grant.nmi) || (prev_q.nmi_n && !sync_q.nmi_n); // RULE16
        end
    end

    // Abort cannot restart a waiting core, but still goes first once it wakes
    always_comb begin
        grant = '0;
        if (!sync_q.rst_n) begin
            grant.rst = 1'b1; // RULE2
        end else if (abort_pend_q && (state_q == ST_RUN || wake)) begin
            grant.abort = 1'b1; // RULE2
        end else if (nmi_pend_q) begin
            grant.nmi = 1'b1; // RULE2
        end else if (!sync_q.irq_n && !pstat_q[`P_I]) begin
            grant.irq = 1'b1; // RULE2
        end
    end
    assign svc_fire = |grant;
    assign wake = state_q == ST_WAIT && (!sync_q.rst_n || nmi_pend_q || !sync_q.irq_n); // RULE15
    assign exec_fire = cmd_pend_q && state_q == ST_RUN && sync_q.ready && !svc_fire;
    assign vec = grant.rst ? VEC_RESET : grant.abort ? VEC_ABORT : grant.nmi ? VEC_NMI : VEC_IRQ;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_pend_q <= 1'b0;
            cmd_op_q <= OP_NOP;
            cmd_bank_q <= 8'h00;
        end else if (wr_fire && aw_addr_q == `REG_CMD && !cmd_pend_q) begin
            cmd_pend_q <= 1'b1;
            cmd_op_q <= op_type'(w_data_q[`CMD_OP_MSB:0]);
            cmd_bank_q <= w_data_q[`CMD_BANK_MSB:`CMD_BANK_LSB];
        end else if (exec_fire) begin
            cmd_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_RUN;
            waiting_indication_n <= 1'b1;
        end else if (exec_fire && cmd_op_q == OP_WAIT) begin
            state_q <= ST_WAIT;
            waiting_indication_n <= 1'b0; // RULE13
        end else if (wake) begin
            state_q <= ST_RUN;
            waiting_indication_n <= 1'b1; // RULE15
        end
    end

    // Architectural state: software writes, then execution, then service
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q <= 16'h0000;
            sp_q <= `SP_RESET;
            dir_q <= 16'h0000;
            idx_q <= 16'h0000;
            dbr_q <= 8'h00;
            pc_q <= VEC_RESET;
            pstat_q <= `PSTAT_RESET;
            emu_q <= 1'b1;
            stkb_q <= 8'h00;
            saved_pc_q <= 16'h0000;
            saved_p_q <= 8'h00;
        end else begin
            if (wr_fire && aw_addr_q == `REG_ACC) acc_q <= wval;
            if (wr_fire && aw_addr_q == `REG_SP) sp_q <= wval;
            if (wr_fire && aw_addr_q == `REG_DIR) dir_q <= wval;
            if (wr_fire && aw_addr_q == `REG_IDX) idx_q <= wval;
            if (wr_fire && aw_addr_q == `REG_DBR) dbr_q <= wval[7:0];
            if (wr_fire && aw_addr_q == `REG_PC) pc_q <= wval;
            if (wr_fire && aw_addr_q == `REG_PSTAT) pstat_q <= wval[7:0];
            if (wr_fire && aw_addr_q == `REG_MODE) emu_q <= wval[`MODE_EMU];
            if (wr_fire && aw_addr_q == `REG_STKB) stkb_q <= wval[7:0];
            if (exec_fire) begin
                pc_q <= pc_q + `OP_LEN;
                case (cmd_op_q)
                    OP_MOVE_ASC, OP_MOVE_DESC: begin
                        dbr_q <= cmd_bank_q; // RULE1
                        pc_q <= pc_q + `MOVE_LEN;
                    end
                    OP_ACC_TO_SP: begin
                        sp_q <= emu_q ? {`SP_EMU_HIGH, acc_q[7:0]} : acc_q; // RULE5 RULE7 RULE8
                    end
                    OP_SP_TO_ACC: begin
                        acc_q <= sp_q; // RULE9 RULE5
                        pstat_q <= set_nz(pstat_q, sp_q, 1'b0);
                    end
                    OP_ACC_TO_DIR: begin
                        dir_q <= acc_q; // RULE5
                        pstat_q <= set_nz(pstat_q, acc_q, 1'b0);
                    end
                    OP_DIR_TO_ACC: begin
                        acc_q <= dir_q; // RULE5
                        pstat_q <= set_nz(pstat_q, dir_q, 1'b0);
                    end
                    OP_ACC_TO_IDX: begin
                        // Narrow index drops the high byte of the full source
                        idx_q <= pstat_q[`P_X] ? {8'h00, acc_q[7:0]} : acc_q; // RULE3 RULE4
                        pstat_q <= set_nz(pstat_q, acc_q, pstat_q[`P_X]); // RULE4
                    end
                    OP_IDX_TO_ACC: begin
                        acc_q <= pstat_q[`P_M] ? {acc_q[15:8], idx_q[7:0]} : idx_q; // RULE3 RULE12
                        pstat_q <= set_nz(pstat_q, idx_q, pstat_q[`P_M]); // RULE4
                    end
                    OP_PUSH_STATUS: stkb_q <= pstat_q; // RULE6
                    OP_PULL_STATUS: pstat_q <= stkb_q; // RULE6
                    OP_BREAK: begin
                        saved_pc_q <= pc_q + `BRK_LEN; // RULE10 RULE11
                        saved_p_q <= pstat_q;
                        pc_q <= VEC_BRK;
                        pstat_q[`P_I] <= 1'b1;
                        pstat_q[`P_D] <= 1'b0;
                    end
                    OP_RETURN: begin
                        pc_q <= saved_pc_q; // RULE11
                        pstat_q <= saved_p_q;
                    end
                    default: begin
                    end
                endcase
            end
            if (svc_fire) begin
                saved_pc_q <= pc_q;
                saved_p_q <= pstat_q;
                pc_q <= vec;
                pstat_q[`P_I] <= 1'b1;
                pstat_q[`P_D] <= 1'b0;
                if (emu_q || grant.rst) dbr_q <= 8'h00;
                if (grant.rst) emu_q <= 1'b1;
            end
            if (emu_q) begin
                sp_q[15:8] <= `SP_EMU_HIGH; // RULE7
                pstat_q[`P_M] <= 1'b1;
                pstat_q[`P_X] <= 1'b1;
            end
        end
    end

    // Sticky events; a new event wins over the clearing read
    assign ev = {exec_fire && cmd_op_q == OP_WAIT, grant};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_q <= '0;
            imask_q <= '0;
            irq <= 1'b0;
        end else begin
            istat_q <= (rd_clear ? '0 : istat_q) | ev;
            if (wr_fire && aw_addr_q == `REG_IMASK) imask_q <= wval[`EV_W-1:0];
            irq <= |(istat_q & imask_q);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_move_bank; // RULE1
        exec_fire && (cmd_op_q == OP_MOVE_ASC || cmd_op_q == OP_MOVE_DESC)
            |=> dbr_q == $past(cmd_bank_q);
    endproperty
    a_move_bank: assert property (p_move_bank) else $error("bank not loaded by move");
    property p_priority; // RULE2
        (!sync_q.rst_n |-> grant == 4'h1) and (grant.irq |-> !nmi_pend_q && !abort_pend_q);
    endproperty
    a_priority: assert property (p_priority) else $error("wrong interrupt priority");
    property p_nmi_stays; // RULE16
        nmi_pend_q && !grant.nmi |=> nmi_pend_q;
    endproperty
    a_nmi_stays: assert property (p_nmi_stays) else $error("pending nmi lost");
    property p_sp_native; // RULE8
        exec_fire && cmd_op_q == OP_ACC_TO_SP && !emu_q |=> sp_q == $past(acc_q);
    endproperty
    a_sp_native: assert property (p_sp_native) else $error("native stack copy wrong");
    property p_sp_emu; // RULE7
        exec_fire && cmd_op_q == OP_ACC_TO_SP && emu_q
            |=> sp_q == {`SP_EMU_HIGH, $past(acc_q[7:0])};
    endproperty
    a_sp_emu: assert property (p_sp_emu) else $error("emulation stack high byte wrong");
    property p_sp_to_acc; // RULE9
        exec_fire && cmd_op_q == OP_SP_TO_ACC |=> acc_q == $past(sp_q);
    endproperty
    a_sp_to_acc: assert property (p_sp_to_acc) else $error("stack to acc not 16 bits");
    property p_keep_high; // RULE12
        exec_fire && cmd_op_q == OP_IDX_TO_ACC && pstat_q[`P_M]
            |=> acc_q == {$past(acc_q[15:8]), $past(idx_q[7:0])};
    endproperty
    a_keep_high: assert property (p_keep_high) else $error("hidden acc byte lost");
    property p_full_src; // RULE3
        exec_fire && cmd_op_q == OP_ACC_TO_IDX && !pstat_q[`P_X] |=> idx_q == $past(acc_q);
    endproperty
    a_full_src: assert property (p_full_src) else $error("wide transfer truncated");
    property p_break; // RULE10
        exec_fire && cmd_op_q == OP_BREAK |=> saved_pc_q == $past(pc_q) + `BRK_LEN;
    endproperty
    a_break: assert property (p_break) else $error("break return address wrong");
    property p_push; // RULE6
        exec_fire && cmd_op_q == OP_PUSH_STATUS |=> stkb_q == $past(pstat_q);
    endproperty
    a_push: assert property (p_push) else $error("status push wrong");
    property p_wait_low; // RULE13
        exec_fire && cmd_op_q == OP_WAIT |=> !waiting_indication_n ##1 (!waiting_indication_n || $past(wake));
    endproperty
    a_wait_low: assert property (p_wait_low) else $error("wait indication not low");
    property p_wake; // RULE15
        state_q == ST_WAIT && !sync_q.rst_n |=> state_q == ST_RUN && waiting_indication_n;
    endproperty
    a_wake: assert property (p_wake) else $error("reset did not end wait");
endmodule

// ---- sim/irq_source_model.sv ----
`timescale 1ns/1ps
module irq_source_model
    import cpu_xfer_pkg::*;
(
    input wire pins_type pull,
    output wire pins_type pins
);
    // A set bit pulls its pin low; every idle pin rests high
    assign pins = pins_type'(~pull);
endmodule

// ---- sim/cpu_transfer_interrupt_semantics_tb.sv ----
`timescale 1ns/1ps
`include "cpu_xfer_defines.svh"
module cpu_transfer_interrupt_semantics_tb
    import cpu_xfer_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, waiting_indication_n;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    pins_type pull, pins;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    cpu_transfer_interrupt_semantics DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .system_reset_n(pins.rst_n),
        .abort_n(pins.abort_n), .nonmaskable_irq_n(pins.nmi_n),
        .maskable_irq_n(pins.irq_n), .ready_input(pins.ready), .irq(irq),
        .waiting_indication_n(waiting_indication_n)
    );
    irq_source_model SRC (.pull(pull), .pins(pins));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Either channel may be taken first, so each is released on its own
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(what, d, exp);
    endtask
    task automatic cmd(input op_type op, input logic [7:0] bank);
        wr(`REG_CMD, {16'h0000, bank, 4'h0, op});
        do rd(`REG_SVC); while (d[`SVC_CMD] !== 1'b0);
    endtask
    task automatic t_reset();
        rdc("sp", `REG_SP, 32'h0000_01ff);
        rdc("pstat", `REG_PSTAT, 32'h0000_0034);
        rdc("mode", `REG_MODE, 32'h0000_0001);
        rdc("unmapped", 8'h3c, 32'h0000_0000);
        check("rresp", r, `RESP_SLVERR);
        wr(8'h3c, 32'h0000_0001);
        check("bresp", r, `RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic t_move();
        cmd(OP_MOVE_ASC, 8'h5a);
        rdc("dbr asc", `REG_DBR, 32'h0000_005a);
        cmd(OP_MOVE_DESC, 8'ha5);
        rdc("dbr desc", `REG_DBR, 32'h0000_00a5);
        $display("test move done");
    endtask
    task automatic t_stack();
        wr(`REG_ACC, 32'h0000_1234);
        cmd(OP_ACC_TO_SP, 8'h00);
        rdc("sp emu", `REG_SP, 32'h0000_0134);
        cmd(OP_SP_TO_ACC, 8'h00);
        rdc("acc emu", `REG_ACC, 32'h0000_0134);
        wr(`REG_MODE, 32'h0000_0000);
        wr(`REG_ACC, 32'h0000_abcd);
        cmd(OP_ACC_TO_SP, 8'h00);
        rdc("sp nat", `REG_SP, 32'h0000_abcd);
        wr(`REG_ACC, 32'h0000_0000);
        cmd(OP_SP_TO_ACC, 8'h00);
        rdc("acc nat", `REG_ACC, 32'h0000_abcd);
        cmd(OP_ACC_TO_DIR, 8'h00);
        rdc("dir", `REG_DIR, 32'h0000_abcd);
        wr(`REG_DIR, 32'h0000_5678);
        cmd(OP_DIR_TO_ACC, 8'h00);
        rdc("acc dir", `REG_ACC, 32'h0000_5678);
        $display("test stack done");
    endtask
    // Narrow accumulator, wide index; then the other way round
    task automatic t_width();
        wr(`REG_ACC, 32'h0000_2345);
        wr(`REG_PSTAT, 32'h0000_0024);
        wr(`REG_IDX, 32'h0000_0080);
        cmd(OP_IDX_TO_ACC, 8'h00);
        rdc("flags acc", `REG_PSTAT, 32'h0000_00a4);
        wr(`REG_PSTAT, 32'h0000_0014);
        rdc("acc kept", `REG_ACC, 32'h0000_2380);
        cmd(OP_ACC_TO_IDX, 8'h00);
        rdc("idx narrow", `REG_IDX, 32'h0000_0080);
        rdc("flags idx", `REG_PSTAT, 32'h0000_0094);
        wr(`REG_PSTAT, 32'h0000_0024);
        cmd(OP_ACC_TO_IDX, 8'h00);
        rdc("idx wide", `REG_IDX, 32'h0000_2380);
        $display("test width done");
    endtask
    task automatic t_status();
        wr(`REG_PSTAT, 32'h0000_00a5);
        cmd(OP_PUSH_STATUS, 8'h00);
        rdc("push", `REG_STKB, 32'h0000_00a5);
        wr(`REG_STKB, 32'h0000_ff3c);
        cmd(OP_PULL_STATUS, 8'h00);
        rdc("pull", `REG_PSTAT, 32'h0000_003c);
        $display("test status done");
    endtask
    task automatic t_break();
        logic [31:0] pc;
        rd(`REG_PC);
        pc = d;
        cmd(OP_BREAK, 8'h00);
        rdc("brk pc", `REG_PC, 32'h0000_0040);
        rdc("brk p", `REG_PSTAT, 32'h0000_0034);
        cmd(OP_RETURN, 8'h00);
        rdc("rti pc", `REG_PC, pc + 32'h0000_0002);
        rdc("rti p", `REG_PSTAT, 32'h0000_003c);
        $display("test break done");
    endtask
    task automatic t_wait();
        wr(`REG_IMASK, 32'h0000_0004);
        rd(`REG_ISTAT);
        cmd(OP_WAIT, 8'h00);
        check("wait ind", waiting_indication_n, 1'b0);
        pull.nmi_n <= 1'b1;
        repeat (2) @(posedge aclk);
        pull.nmi_n <= 1'b0;
        while (waiting_indication_n !== 1'b1) @(posedge aclk);
        repeat (2) @(posedge aclk);
        rdc("wake pc", `REG_PC, 32'h0000_0020);
        check("irq set", irq, 1'b1);
        rdc("istat", `REG_ISTAT, 32'h0000_0014);
        repeat (3) @(posedge aclk);
        check("irq clr", irq, 1'b0);
        $display("test wait done");
    endtask
    // Abort must win, so the nonmaskable vector is the last one taken
    task automatic t_prio();
        pull.abort_n <= 1'b1;
        pull.nmi_n <= 1'b1;
        @(posedge aclk);
        pull.abort_n <= 1'b0;
        pull.nmi_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc("both pend", `REG_ISTAT, 32'h0000_0006);
        rdc("order pc", `REG_PC, 32'h0000_0020);
        pull.rst_n <= 1'b1;
        pull.irq_n <= 1'b1;
        repeat (4) @(posedge aclk);
        pull.rst_n <= 1'b0;
        pull.irq_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rdc("rst pc", `REG_PC, 32'h0000_0000);
        rdc("rst ist", `REG_ISTAT, 32'h0000_0001);
        rdc("rst mode", `REG_MODE, 32'h0000_0001);
        $display("test priority done");
    endtask
    // Stalled by ready, then a maskable request; abort caught in wait goes first
    task automatic t_irq();
        pull.ready <= 1'b1;
        wr(`REG_PSTAT, 32'h0000_0030);
        rd(`REG_ISTAT);
        wr(`REG_CMD, {28'h0000000, OP_NOP});
        repeat (4) @(posedge aclk);
        rdc("stall", `REG_SVC, 32'h0000_0002);
        pull.irq_n <= 1'b1;
        repeat (4) @(posedge aclk);
        pull.irq_n <= 1'b0;
        rdc("irq pc", `REG_PC, 32'h0000_0030);
        pull.ready <= 1'b0;
        do rd(`REG_SVC); while (d[`SVC_CMD] !== 1'b0);
        rdc("nop pc", `REG_PC, 32'h0000_0031);
        cmd(OP_WAIT, 8'h00);
        pull.abort_n <= 1'b1;
        @(posedge aclk);
        pull.abort_n <= 1'b0;
        repeat (6) @(posedge aclk);
        check("abort no wake", waiting_indication_n, 1'b0);
        pull.nmi_n <= 1'b1;
        @(posedge aclk);
        pull.nmi_n <= 1'b0;
        while (waiting_indication_n !== 1'b1) @(posedge aclk);
        rdc("abort first", `REG_PC, 32'h0000_0020);
        rdc("wait ist", `REG_ISTAT, 32'h0000_001e);
        $display("test interrupt done");
    endtask
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        pull = pins_type'(5'h00);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_move();
        t_stack();
        t_width();
        t_status();
        t_break();
        t_wait();
        t_prio();
        t_irq();
        give_verdict();
    end
endmodule
